// *** bbx_shift_unit.sv ***
// Package of shared encodings, plus the shift, rotate and swap datapath.
// Assumes a single core clock; the datapath itself is purely combinational.
package bbx_pkg;
    // Status flag positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BIT_ONE     = 8'h01;
    // Cycle counts
    localparam logic [1:0] CYC_SINGLE       = 2'h1;
    localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE     = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO     = 2'h3;
    // Program counter steps in words
    localparam int PC_STEP_NEXT     = 1;
    localparam int PC_STEP_SKIP_ONE = 2;
    localparam int PC_STEP_SKIP_TWO = 3;

    typedef enum logic [5:0] {
        OP_NOP                  = 6'b000000,
        OP_SKIP_IF_IO_BIT_CLEAR = 6'b000001,
        OP_SKIP_IF_IO_BIT_SET   = 6'b000010,
        OP_BRANCH_FLAG_SET      = 6'b000011,
        OP_BRANCH_FLAG_CLEAR    = 6'b000100,
        OP_BRANCH_EQUAL         = 6'b000101,
        OP_BRANCH_NOT_EQUAL     = 6'b000110,
        OP_BRANCH_CARRY_SET     = 6'b000111,
        OP_BRANCH_CARRY_CLEAR   = 6'b001000,
        OP_BRANCH_SAME_HIGHER   = 6'b001001,
        OP_BRANCH_LOWER         = 6'b001010,
        OP_BRANCH_MINUS         = 6'b001011,
        OP_BRANCH_PLUS          = 6'b001100,
        OP_BRANCH_SIGNED_GE     = 6'b001101,
        OP_BRANCH_SIGNED_LT     = 6'b001110,
        OP_BRANCH_HALFCARRY_SET = 6'b001111,
        OP_BRANCH_HALFCARRY_CLR = 6'b010000,
        OP_BRANCH_TRANSFER_SET  = 6'b010001,
        OP_BRANCH_TRANSFER_CLR  = 6'b010010,
        OP_BRANCH_OVERFLOW_SET  = 6'b010011,
        OP_BRANCH_OVERFLOW_CLR  = 6'b010100,
        OP_BRANCH_IRQ_ENABLED   = 6'b010101,
        OP_BRANCH_IRQ_DISABLED  = 6'b010110,
        OP_SHIFT_LEFT_LOGICAL   = 6'b010111,
        OP_SHIFT_RIGHT_LOGICAL  = 6'b011000,
        OP_ROTATE_LEFT_CARRY    = 6'b011001,
        OP_ROTATE_RIGHT_CARRY   = 6'b011010,
        OP_SHIFT_RIGHT_ARITH    = 6'b011011,
        OP_NIBBLE_SWAP          = 6'b011100,
        OP_FLAG_FORCE_ONE       = 6'b011101,
        OP_FLAG_FORCE_ZERO      = 6'b011110,
        OP_IO_BIT_FORCE_ONE     = 6'b011111,
        OP_IO_BIT_FORCE_ZERO    = 6'b100000,
        OP_BIT_TO_TRANSFER_FLAG = 6'b100001,
        OP_TRANSFER_FLAG_TO_BIT = 6'b100010,
        OP_CARRY_FORCE_ONE      = 6'b100011,
        OP_CARRY_FORCE_ZERO     = 6'b100100,
        OP_NEGATIVE_FORCE_ONE   = 6'b100101,
        OP_NEGATIVE_FORCE_ZERO  = 6'b100110,
        OP_ZERO_FORCE_ONE       = 6'b100111,
        OP_ZERO_FORCE_ZERO      = 6'b101000,
        OP_IRQ_GLOBAL_ON        = 6'b101001,
        OP_IRQ_GLOBAL_OFF       = 6'b101010,
        OP_SIGNED_FORCE_ONE     = 6'b101011,
        OP_SIGNED_FORCE_ZERO    = 6'b101100,
        OP_OVERFLOW_FORCE_ONE   = 6'b101101,
        OP_OVERFLOW_FORCE_ZERO  = 6'b101110,
        OP_TRANSFER_FORCE_ONE   = 6'b101111,
        OP_TRANSFER_FORCE_ZERO  = 6'b110000,
        OP_HALFCARRY_FORCE_ONE  = 6'b110001,
        OP_HALFCARRY_FORCE_ZERO = 6'b110010
    } bbx_op_type;

    typedef enum logic [0:0] {
        ST_READY = 1'b0,
        ST_STALL = 1'b1
    } bbx_state_type;

    // Fixed-flag ops: {hit, flag index, wanted or forced value}
    function automatic logic [4:0] bbx_flag_map(input bbx_op_type op);
        case (op)
            OP_BRANCH_EQUAL:         bbx_flag_map = {1'b1, FLAG_Z, 1'b1};
            OP_BRANCH_NOT_EQUAL:     bbx_flag_map = {1'b1, FLAG_Z, 1'b0};
            OP_BRANCH_CARRY_SET:     bbx_flag_map = {1'b1, FLAG_C, 1'b1};
            OP_BRANCH_LOWER:         bbx_flag_map = {1'b1, FLAG_C, 1'b1};
            OP_BRANCH_CARRY_CLEAR:   bbx_flag_map = {1'b1, FLAG_C, 1'b0};
            OP_BRANCH_SAME_HIGHER:   bbx_flag_map = {1'b1, FLAG_C, 1'b0};
            OP_BRANCH_MINUS:         bbx_flag_map = {1'b1, FLAG_N, 1'b1};
            OP_BRANCH_PLUS:          bbx_flag_map = {1'b1, FLAG_N, 1'b0};
            OP_BRANCH_HALFCARRY_SET: bbx_flag_map = {1'b1, FLAG_H, 1'b1};
            OP_BRANCH_HALFCARRY_CLR: bbx_flag_map = {1'b1, FLAG_H, 1'b0};
            OP_BRANCH_TRANSFER_SET:  bbx_flag_map = {1'b1, FLAG_T, 1'b1};
            OP_BRANCH_TRANSFER_CLR:  bbx_flag_map = {1'b1, FLAG_T, 1'b0};
            OP_BRANCH_OVERFLOW_SET:  bbx_flag_map = {1'b1, FLAG_V, 1'b1};
            OP_BRANCH_OVERFLOW_CLR:  bbx_flag_map = {1'b1, FLAG_V, 1'b0};
            OP_BRANCH_IRQ_ENABLED:   bbx_flag_map = {1'b1, FLAG_I, 1'b1};
            OP_BRANCH_IRQ_DISABLED:  bbx_flag_map = {1'b1, FLAG_I, 1'b0};
            OP_CARRY_FORCE_ONE:      bbx_flag_map = {1'b1, FLAG_C, 1'b1};
            OP_CARRY_FORCE_ZERO:     bbx_flag_map = {1'b1, FLAG_C, 1'b0};
            OP_NEGATIVE_FORCE_ONE:   bbx_flag_map = {1'b1, FLAG_N, 1'b1};
            OP_NEGATIVE_FORCE_ZERO:  bbx_flag_map = {1'b1, FLAG_N, 1'b0};
            OP_ZERO_FORCE_ONE:       bbx_flag_map = {1'b1, FLAG_Z, 1'b1};
            OP_ZERO_FORCE_ZERO:      bbx_flag_map = {1'b1, FLAG_Z, 1'b0};
            OP_IRQ_GLOBAL_ON:        bbx_flag_map = {1'b1, FLAG_I, 1'b1};
            OP_IRQ_GLOBAL_OFF:       bbx_flag_map = {1'b1, FLAG_I, 1'b0};
            OP_SIGNED_FORCE_ONE:     bbx_flag_map = {1'b1, FLAG_S, 1'b1};
            OP_SIGNED_FORCE_ZERO:    bbx_flag_map = {1'b1, FLAG_S, 1'b0};
            OP_OVERFLOW_FORCE_ONE:   bbx_flag_map = {1'b1, FLAG_V, 1'b1};
            OP_OVERFLOW_FORCE_ZERO:  bbx_flag_map = {1'b1, FLAG_V, 1'b0};
            OP_TRANSFER_FORCE_ONE:   bbx_flag_map = {1'b1, FLAG_T, 1'b1};
            OP_TRANSFER_FORCE_ZERO:  bbx_flag_map = {1'b1, FLAG_T, 1'b0};
            OP_HALFCARRY_FORCE_ONE:  bbx_flag_map = {1'b1, FLAG_H, 1'b1};
            OP_HALFCARRY_FORCE_ZERO: bbx_flag_map = {1'b1, FLAG_H, 1'b0};
            default:                 bbx_flag_map = 5'h00;
        endcase
    endfunction : bbx_flag_map
endpackage : bbx_pkg

module bbx_shift_unit
    import bbx_pkg::*;
(
    // Operation
    input  wire bbx_op_type op,
    input  wire logic [7:0] value,
    input  wire logic [7:0] flags_in,
    // Result
    output logic            hit,
    output logic [7:0]      result,
    output logic [7:0]      flags_out
);
    logic       carry_out;
    logic       neg;
    logic       ovf;
    logic       keep_h;

    assign hit = (op == OP_SHIFT_LEFT_LOGICAL) || (op == OP_SHIFT_RIGHT_LOGICAL)
               || (op == OP_ROTATE_LEFT_CARRY) || (op == OP_ROTATE_RIGHT_CARRY)
               || (op == OP_SHIFT_RIGHT_ARITH) || (op == OP_NIBBLE_SWAP);

    always_comb begin
        result    = value;
        carry_out = flags_in[FLAG_C];
        keep_h    = 1'b1;
        case (op)
            OP_SHIFT_LEFT_LOGICAL: begin
                result    = {value[6:0], 1'b0};
                carry_out = value[7];
                keep_h    = 1'b0;
            end
            OP_ROTATE_LEFT_CARRY: begin
                result    = {value[6:0], flags_in[FLAG_C]};
                carry_out = value[7];
                keep_h    = 1'b0;
            end
            OP_ROTATE_RIGHT_CARRY: begin
                result    = {flags_in[FLAG_C], value[7:1]};
                carry_out = value[0];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                result    = {1'b0, value[7:1]};
                carry_out = value[0];
            end
            OP_SHIFT_RIGHT_ARITH: begin
                result    = {value[7], value[7:1]};
                carry_out = value[0];
            end
            OP_NIBBLE_SWAP: result = {value[3:0], value[7:4]};
            default: result = value;
        endcase
    end

    assign neg = result[7];
    assign ovf = neg ^ carry_out;

    always_comb begin
        flags_out = flags_in;
        if (hit && (op != OP_NIBBLE_SWAP)) begin
            flags_out[FLAG_C] = carry_out;
            flags_out[FLAG_Z] = (result == 8'h00);
            flags_out[FLAG_N] = neg;
            flags_out[FLAG_V] = ovf;
            flags_out[FLAG_S] = neg ^ ovf;
            // Left shifts expose bit 3 as the half carry
            flags_out[FLAG_H] = keep_h ? flags_in[FLAG_H] : value[3];
        end
    end
endmodule : bbx_shift_unit

// *** bbx_exec.sv ***
// Executes branch, skip, shift, bit-transfer and status-flag instructions.
// Assumes a decoded op with operand fields from the core's decoder, a
// register file read port and a same-clock I/O bus with combinational read.
// Function
// - I/O bit skip takes 1, 2 or 3 cycles by skipped instruction length
// - Flag branch on bit s: taken goes to PC+k+1 in 2 cycles, else 1
// - Equal, carry and minus branches test Z, C and N with given polarity
// - Signed GE branches on N xor V clear, signed LT on set
// - Half-carry, transfer and overflow branches exist for set and clear
// - Interrupt-enable branches test I and alter no status flag
// - Shift left and rotate left update Z,C,N,V,H in one cycle
// - Rotate right through carry updates Z,C,N,V in one cycle
// - Logical and arithmetic right shifts update Z,C,N,V in one cycle
// - Bit store to T, bit load from T, nibble swap, one cycle
// - I/O bit set or clear keeps other bits and flags, one cycle
// - Dedicated and generic one-cycle flag set and clear touch one flag
// - Global interrupt on and off change only I, one cycle
module bbx_exec
    import bbx_pkg::*;
#(
    parameter int PC_WIDTH = 9
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    // Decoded instruction
    input  wire logic                instr_valid,
    input  wire bbx_op_type          instr_op,
    input  wire logic [2:0]          flag_index,
    input  wire logic [2:0]          bit_index,
    input  wire logic [5:0]          io_addr,
    input  wire logic [6:0]          branch_offset,
    input  wire logic                next_two_word,
    output logic                     instr_ready,
    // Register file
    input  wire logic [7:0]          reg_value,
    output logic [7:0]               reg_wdata,
    output logic                     reg_we,
    // I/O bus
    output logic [5:0]               io_rd_addr,
    input  wire logic [7:0]          io_rdata,
    output logic [5:0]               io_wr_addr,
    output logic [7:0]               io_wdata,
    output logic                     io_we,
    // Core state
    output logic [7:0]               status_flags,
    output logic [PC_WIDTH-1:0]      pc
);
    localparam logic [1:0] WAIT_NONE = 2'h0;

    bbx_state_type         state;
    logic [1:0]            wait_left;
    logic                  accept;
    logic [4:0]            flag_map;
    logic                  map_hit;
    logic [2:0]            map_idx;
    logic                  map_pol;
    logic                  is_gen_branch;
    logic                  is_signed_branch;
    logic                  is_fixed_branch;
    logic                  is_branch;
    logic [2:0]            sel_idx;
    logic                  want;
    logic                  cond_bit;
    logic                  taken;
    logic                  is_skip;
    logic                  io_bit;
    logic                  skip_hit;
    logic [1:0]            cycles;
    logic [PC_WIDTH-1:0]   offset_ext;
    logic [PC_WIDTH-1:0]   next_pc;
    logic                  is_gen_flag;
    logic                  is_fixed_flag;
    logic                  flag_write;
    logic                  flag_pol;
    logic [7:0]            flag_mask;
    logic [7:0]            forced_flags;
    logic [7:0]            bst_flags;
    logic [7:0]            bit_mask;
    logic                  is_io_bit;
    logic                  is_bld;
    logic                  is_bst;
    logic                  sh_hit;
    logic [7:0]            sh_result;
    logic [7:0]            sh_flags;
    logic [7:0]            next_flags;
    logic [7:0]            next_reg_wdata;

    assign state       = (wait_left == WAIT_NONE) ? ST_READY : ST_STALL;
    assign instr_ready = (state == ST_READY);
    assign accept      = instr_valid && instr_ready;
    assign io_rd_addr  = io_addr;

    // Flag selection shared by branches and flag writes
    assign flag_map         = bbx_flag_map(instr_op);
    assign map_hit          = flag_map[4];
    assign map_idx          = flag_map[3:1];
    assign map_pol          = flag_map[0];
    assign is_gen_branch    = (instr_op == OP_BRANCH_FLAG_SET)
                            || (instr_op == OP_BRANCH_FLAG_CLEAR);
    assign is_signed_branch = (instr_op == OP_BRANCH_SIGNED_GE)
                            || (instr_op == OP_BRANCH_SIGNED_LT);
    assign is_fixed_branch  = map_hit && (instr_op <= OP_BRANCH_IRQ_DISABLED);
    assign is_branch        = is_gen_branch || is_signed_branch || is_fixed_branch;
    assign is_gen_flag      = (instr_op == OP_FLAG_FORCE_ONE)
                            || (instr_op == OP_FLAG_FORCE_ZERO);
    assign is_fixed_flag    = map_hit && (instr_op >= OP_CARRY_FORCE_ONE);
    assign sel_idx          = (is_gen_branch || is_gen_flag) ? flag_index : map_idx;

    // Branch condition
    assign want     = is_gen_branch    ? (instr_op == OP_BRANCH_FLAG_SET)
                    : is_signed_branch ? (instr_op == OP_BRANCH_SIGNED_LT)
                    : map_pol;
    assign cond_bit = is_signed_branch ? (status_flags[FLAG_N] ^ status_flags[FLAG_V])
                                       : status_flags[sel_idx];
    assign taken    = is_branch && (cond_bit == want);

    // Skip on I/O bit
    assign is_skip  = (instr_op == OP_SKIP_IF_IO_BIT_CLEAR)
                    || (instr_op == OP_SKIP_IF_IO_BIT_SET);
    assign io_bit   = io_rdata[bit_index];
    assign skip_hit = is_skip && (io_bit == (instr_op == OP_SKIP_IF_IO_BIT_SET));

    assign cycles = taken    ? CYC_BRANCH_TAKEN
                  : skip_hit ? (next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE)
                  : CYC_SINGLE;

    // Offset is a signed word count
    assign offset_ext = PC_WIDTH'($signed(branch_offset));
    assign next_pc    = taken    ? pc + offset_ext + PC_WIDTH'(PC_STEP_NEXT)
                      : skip_hit ? pc + (next_two_word ? PC_WIDTH'(PC_STEP_SKIP_TWO)
                                                       : PC_WIDTH'(PC_STEP_SKIP_ONE))
                      : pc + PC_WIDTH'(PC_STEP_NEXT);

    // Flag writes
    assign flag_write   = is_gen_flag || is_fixed_flag;
    assign flag_pol     = is_gen_flag ? (instr_op == OP_FLAG_FORCE_ONE) : map_pol;
    assign flag_mask    = BIT_ONE << sel_idx;
    assign forced_flags = flag_pol ? (status_flags | flag_mask)
                                   : (status_flags & ~flag_mask);
    assign bit_mask     = BIT_ONE << bit_index;
    assign is_bst       = (instr_op == OP_BIT_TO_TRANSFER_FLAG);
    assign is_bld       = (instr_op == OP_TRANSFER_FLAG_TO_BIT);
    assign bst_flags    = reg_value[bit_index] ? (status_flags | (BIT_ONE << FLAG_T))
                                               : (status_flags & ~(BIT_ONE << FLAG_T));
    assign is_io_bit    = (instr_op == OP_IO_BIT_FORCE_ONE)
                        || (instr_op == OP_IO_BIT_FORCE_ZERO);

    bbx_shift_unit u_shift (
        .op        (instr_op),
        .value     (reg_value),
        .flags_in  (status_flags),
        .hit       (sh_hit),
        .result    (sh_result),
        .flags_out (sh_flags)
    );

    // Branches, skips, swap and I/O bit ops leave the flags alone
    assign next_flags = !accept   ? status_flags
                      : sh_hit    ? sh_flags
                      : flag_write? forced_flags
                      : is_bst    ? bst_flags
                      : status_flags;

    assign next_reg_wdata = is_bld ? (status_flags[FLAG_T] ? (reg_value | bit_mask)
                                                           : (reg_value & ~bit_mask))
                                   : sh_result;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wait_left <= WAIT_NONE;
        end else if (accept) begin
            wait_left <= cycles - CYC_SINGLE;
        end else if (wait_left != WAIT_NONE) begin
            wait_left <= wait_left - CYC_SINGLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc           <= '0;
            status_flags <= FLAGS_RESET;
        end else begin
            if (accept) begin
                pc <= next_pc;
            end
            status_flags <= next_flags;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_we    <= 1'b0;
            reg_wdata <= 8'h00;
        end else begin
            reg_we    <= accept && (sh_hit || is_bld);
            reg_wdata <= next_reg_wdata;
        end
    end

    // Read-modify-write of the I/O location in the accepting cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            io_we      <= 1'b0;
            io_wr_addr <= 6'h00;
            io_wdata   <= 8'h00;
        end else begin
            io_we      <= accept && is_io_bit;
            io_wr_addr <= io_addr;
            io_wdata   <= (instr_op == OP_IO_BIT_FORCE_ONE) ? (io_rdata | bit_mask)
                                                            : (io_rdata & ~bit_mask);
        end
    end

    // Checks
    default clocking dflt @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence one_stall_s;
        !instr_ready ##1 instr_ready;
    endsequence

    sequence two_stall_s;
        !instr_ready [*2] ##1 instr_ready;
    endsequence

    skip_three_cycle_a: assert property (
        accept && skip_hit && next_two_word |=> two_stall_s)
        else $error("two-word skip did not take three cycles");
    skip_none_a: assert property (
        accept && is_skip && !skip_hit |=> instr_ready && pc == $past(pc) + 1'b1)
        else $error("skip not taken altered timing or pc");
    branch_taken_pc_a: assert property (
        accept && taken |=> (pc == $past(pc) + $past(offset_ext) + 1'b1) ##0 one_stall_s)
        else $error("taken branch target or timing wrong");
    branch_equal_cond_a: assert property (
        accept && instr_op == OP_BRANCH_EQUAL |-> taken == status_flags[FLAG_Z])
        else $error("equal branch condition wrong");
    signed_ge_cond_a: assert property (
        accept && instr_op == OP_BRANCH_SIGNED_GE
        |-> taken == !(status_flags[FLAG_N] ^ status_flags[FLAG_V]))
        else $error("signed ge condition wrong");
    halfcarry_clear_a: assert property (
        accept && instr_op == OP_BRANCH_HALFCARRY_CLR |-> taken == !status_flags[FLAG_H])
        else $error("half carry clear branch wrong");
    irq_branch_flags_a: assert property (
        accept && instr_op == OP_BRANCH_IRQ_ENABLED |=> $stable(status_flags))
        else $error("interrupt branch changed flags");
    shift_left_a: assert property (
        accept && instr_op == OP_SHIFT_LEFT_LOGICAL |=> reg_we && instr_ready
        && reg_wdata == {$past(reg_value[6:0]), 1'b0}
        && status_flags[FLAG_C] == $past(reg_value[7])
        && status_flags[FLAG_H] == $past(reg_value[3]))
        else $error("shift left result or flags wrong");
    rotate_right_a: assert property (
        accept && instr_op == OP_ROTATE_RIGHT_CARRY |=> reg_we
        && reg_wdata == {$past(status_flags[FLAG_C]), $past(reg_value[7:1])}
        && status_flags[FLAG_C] == $past(reg_value[0]))
        else $error("rotate right result or carry wrong");
    arith_right_a: assert property (
        accept && instr_op == OP_SHIFT_RIGHT_ARITH |=> reg_we
        && reg_wdata[7] == $past(reg_value[7])
        && status_flags[FLAG_Z] == (reg_wdata == 8'h00))
        else $error("arithmetic shift wrong");
    bit_store_a: assert property (
        accept && is_bst |=> status_flags[FLAG_T] == $past(reg_value[bit_index]) && !reg_we)
        else $error("bit store to transfer flag wrong");
    io_bit_set_a: assert property (
        accept && instr_op == OP_IO_BIT_FORCE_ONE |=> io_we && io_wdata[$past(bit_index)]
        && $stable(status_flags) && io_wr_addr == $past(io_addr))
        else $error("io bit set wrong");
    flag_force_a: assert property (
        accept && is_gen_flag |=> status_flags[$past(flag_index)] == $past(flag_pol)
        && instr_ready)
        else $error("generic flag write wrong");
    irq_on_a: assert property (
        accept && instr_op == OP_IRQ_GLOBAL_ON
        |=> status_flags == ($past(status_flags) | (BIT_ONE << FLAG_I)))
        else $error("interrupt enable changed other flags");
    flag_index_a: assert property (
        accept && instr_op == OP_BRANCH_FLAG_SET && flag_index == FLAG_I
        |-> taken == status_flags[7])
        else $error("flag index numbering wrong");
    skip_two_cycle_a: assert property (
        accept && skip_hit && !next_two_word
        |=> (pc == $past(pc) + PC_WIDTH'(PC_STEP_SKIP_ONE)) ##0 one_stall_s)
        else $error("one-word skip target or timing wrong");
    nibble_swap_a: assert property (
        accept && instr_op == OP_NIBBLE_SWAP |=> reg_we && $stable(status_flags)
        && reg_wdata == {$past(reg_value[3:0]), $past(reg_value[7:4])})
        else $error("nibble swap result or flags wrong");
    bit_load_a: assert property (
        accept && is_bld |=> reg_we && $stable(status_flags)
        && reg_wdata[$past(bit_index)] == status_flags[FLAG_T])
        else $error("bit load from transfer flag wrong");
    io_bit_clear_a: assert property (
        accept && instr_op == OP_IO_BIT_FORCE_ZERO |=> io_we && !io_wdata[$past(bit_index)]
        && (io_wdata | $past(bit_mask)) == ($past(io_rdata) | $past(bit_mask)))
        else $error("io bit clear wrong");
endmodule : bbx_exec

// *** bbx_exec_tb.sv ***
// Self-checking bench for bbx_exec: a fixed op sequence with random operands against a reference model.
// Assumes the design holds its own timing assertions; this bench checks values and stalls.
module testbench
    import bbx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [8:0] p; logic [7:0] f; logic rw; logic [7:0] rd; logic iw; logic [7:0] id;
        logic [5:0] a;
    } bbx_note_type;
    logic        ref_clk, sys_rst, instr_valid, next_two_word, instr_ready, reg_we, io_we, acc;
    bbx_op_type  instr_op;
    logic [2:0]  flag_index, bit_index;
    logic [5:0]  io_addr, io_rd_addr, io_wr_addr;
    logic [6:0]  branch_offset;
    logic [7:0]  reg_value, reg_wdata, io_rdata, io_wdata, status_flags, f;
    logic [8:0]  pc, p;
    integer      seed, miscompares, check_count, stl;
    bbx_note_type q[$];
    bbx_note_type e;
    // Fixed-flag branches: {flag index, wanted value}, indexed by op code
    logic [3:0]  bt [23] = '{0, 0, 0, 0, 0, 3, 2, 1, 0, 0, 1, 5, 4, 0, 1, 11, 10, 13, 12, 7, 6, 15, 14};
    // Dedicated flag ops come in one/zero pairs in this flag order
    logic [2:0]  ft [8] = '{0, 2, 1, 7, 4, 3, 6, 5};

    bbx_exec #(.PC_WIDTH(9)) dut (.ref_clk, .sys_rst, .instr_valid, .instr_op, .flag_index,
        .bit_index, .io_addr, .branch_offset, .next_two_word, .instr_ready, .reg_value,
        .reg_wdata, .reg_we, .io_rd_addr, .io_rdata, .io_wr_addr, .io_wdata, .io_we,
        .status_flags, .pc);

    task automatic chk(input string n, input logic [8:0] x, input logic [8:0] g);
        check_count++;
        if (x !== g) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic final_report;
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic run(input int o);
        int n;
        bbx_note_type x;
        logic c, t, v;
        logic [7:0] r;
        n = 0;
        @(negedge ref_clk);
        while (instr_ready !== 1'b1 && n < 9) begin
            n++;
            @(negedge ref_clk);
        end
        chk("stall", 9'(stl), 9'(n));
        chk("io_rd_addr", 9'(io_addr), 9'(io_rd_addr));
        {flag_index, bit_index, io_addr, branch_offset, next_two_word} = 20'($random(seed));
        reg_value = 8'($random(seed));
        io_rdata = 8'($random(seed));
        instr_op = bbx_op_type'(o[5:0]);
        instr_valid = 1'b1;
        x = '{p + 9'h1, f, 1'b0, 8'h00, 1'b0, 8'h00, io_addr};
        stl = 0;
        r = reg_value;
        if (o >= 1 && o <= 22) begin
            v = o == 13 || o == 14 ? f[2] ^ f[3] : f[o < 5 ? flag_index : bt[o][3:1]];
            t = o <= 2 ? io_rdata[bit_index] == (o == 2) : v == (o < 5 ? o == 3 : bt[o][0]);
            stl = t ? (o <= 2 ? 1 + next_two_word : 1) : 0;
            if (t && o <= 2) x.p = p + 9'(2 + next_two_word);
            if (t && o > 2) x.p = p + {{2{branch_offset[6]}}, branch_offset} + 9'h1;
        end
        if (o >= 23 && o <= 27) begin
            case (o)
                23: {c, r} = {reg_value, 1'b0};
                24: {r, c} = {1'b0, reg_value};
                25: {c, r} = {reg_value, f[0]};
                26: {r, c} = {f[0], reg_value};
                default: {r, c} = {reg_value[7], reg_value};
            endcase
            x.f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
            x.f[4] = x.f[2] ^ x.f[3];
            if (o == 23 || o == 25) x.f[5] = reg_value[3];
        end
        if (o == 28) r = {reg_value[3:0], reg_value[7:4]};
        if (o == 34) r[bit_index] = f[6];
        if (o >= 23 && o <= 28 || o == 34) x.rw = 1'b1;
        x.rd = r;
        if (o == 29 || o == 30) x.f[flag_index] = o == 29;
        x.iw = o == 31 || o == 32;
        x.id = o == 31 ? io_rdata | (8'h01 << bit_index) : io_rdata & ~(8'h01 << bit_index);
        if (o == 33) x.f[6] = reg_value[bit_index];
        if (o >= 35) x.f[ft[(o - 35) / 2]] = o[0];
        p = x.p;
        f = x.f;
        q.push_back(x);
    endtask : run

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Outputs are registered, so the note for an accept is checked one edge later
    always @(posedge ref_clk) acc <= instr_valid && instr_ready && !sys_rst;
    always @(negedge ref_clk) begin
        if (acc === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk("pc", e.p, pc);
            chk("status_flags", 9'(e.f), 9'(status_flags));
            chk("reg_we", 9'(e.rw), 9'(reg_we));
            chk("io_we", 9'(e.iw), 9'(io_we));
            if (e.rw) chk("reg_wdata", 9'(e.rd), 9'(reg_wdata));
            if (e.iw) chk("io_wdata", 9'(e.id), 9'(io_wdata));
            if (e.iw) chk("io_wr_addr", 9'(e.a), 9'(io_wr_addr));
        end
    end

    initial begin
        #200000;
        miscompares++;
        final_report();
    end

    initial begin
        seed = 32'h185944d5;
        miscompares = 0;
        check_count = 0;
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_op = OP_NOP;
        {flag_index, bit_index, io_addr, branch_offset, next_two_word} = 20'h00000;
        reg_value = 8'h00;
        io_rdata = 8'h00;
        p = 9'h000;
        f = FLAGS_RESET;
        stl = 0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk) sys_rst = 1'b0;
        chk("pc", 9'h000, pc);
        chk("status_flags", 9'(FLAGS_RESET), 9'(status_flags));
        for (int i = 0; i < 16; i++) run(35 + i);
        for (int i = 0; i < 80; i++) begin
            run(29 + i % 2);
            run(1 + i % 22);
            run(3 + i % 2);
        end
        for (int i = 0; i < 60; i++) run(23 + i % 12);
        run(0);
        @(negedge ref_clk) instr_valid = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("notes_left", 9'h000, 9'(q.size()));
        final_report();
    end
endmodule : testbench
